/* pkg/arbu_consts.vh */
`ifndef ARBU_CONSTS_VH
`define ARBU_CONSTS_VH

// Register byte offsets and bus response codes
`define ARBU_A_ACC     5'h00
`define ARBU_A_CMD     5'h04
`define ARBU_A_SHIFT   5'h08
`define ARBU_A_STAT    5'h0c
`define ARBU_RESP_OK   2'b00
`define ARBU_RESP_DEC  2'b11

// Reset values
`define ARBU_RST_ACC   32'h0000_0000
`define ARBU_RST_SHIFT 32'h0000_0001

// Operation codes
`define ARBU_OP_SIN    4'h0
`define ARBU_OP_COS    4'h1
`define ARBU_OP_TAN    4'h2
`define ARBU_OP_ASIN   4'h3
`define ARBU_OP_ACOS   4'h4
`define ARBU_OP_ATAN   4'h5
`define ARBU_OP_SQRT   4'h6
`define ARBU_OP_POP    4'h7
`define ARBU_OP_SHL    4'h8

// Status bit positions
`define ARBU_ST_ZERO   0
`define ARBU_ST_NEG    1
`define ARBU_ST_VALID  2
`define ARBU_ST_SERR   3
`define ARBU_ST_NREAL  4
`define ARBU_ST_RANGE  5
`define ARBU_ST_BUSY   8

// Fixed point Q7.24 constants, then float NaN and exponent limits
`define ARBU_ONE       32'h0100_0000
`define ARBU_K         32'h009b_74ee
`define ARBU_PI        32'h0324_3f6b
`define ARBU_HALF_PI   32'h0192_1fb5
`define ARBU_TWO_PI    32'h0648_7ed5
`define ARBU_AT0       32'h00c9_0fdb
`define ARBU_AT1       32'h0076_b19c
`define ARBU_AT2       32'h003e_b6ec
`define ARBU_AT3       32'h001f_d5bb
`define ARBU_AT4       32'h000f_faae
`define ARBU_AT5       32'h0007_ff55
`define ARBU_AT6       32'h0003_ffeb
`define ARBU_AT7       32'h0001_fffd
`define ARBU_AT8       32'h0001_0000
`define ARBU_NAN       32'h7fc0_0000
`define ARBU_EXP_BIG   8'h85
`define ARBU_EXP_ONE   8'h7f

// Iteration counts
`define ARBU_CORD_N    6'd24
`define ARBU_SQRT_N    6'd25
`define ARBU_DIV_N     6'd56

`endif

/* rtl/arbu_acc_math.v */
`timescale 1ns/1ps
`include "arbu_consts.vh"
// Behaviour
// - Real functions read and write accumulator only
// - Sine of single-precision accumulator value
// - Cosine of single-precision accumulator value
// - Tangent of single-precision accumulator value
// - Arc sine of single-precision accumulator value
// - Arc cosine of single-precision accumulator value
// - Arc tangent of single-precision accumulator value
// - Square root accepts every positive real
// - Trig angles are radians, never degrees
// - Zero flag follows zero result
// - Negative flag follows negative result
// - Valid-float flag after transcendental operations
// - Sign-error flag on wrong signed sign
// - Non-real flag on non-real operand
// - Range flag when operand too large
// - Population count into accumulator, zero flag
// - Left shift spans full accumulator width
// - Shift distance from operand, one to 32
// - Zero fill, shifted-out bits lost
module arbu_acc_math #(
  parameter ADDR_W = 5
) (
  input  wire              clk_sys_i,
  input  wire              reset_i,
  input  wire [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire              s_axi_awvalid_i,
  output reg               s_axi_awready_o,
  input  wire [31:0]       s_axi_wdata_i,
  input  wire [3:0]        s_axi_wstrb_i,
  input  wire              s_axi_wvalid_i,
  output reg               s_axi_wready_o,
  output reg  [1:0]        s_axi_bresp_o,
  output reg               s_axi_bvalid_o,
  input  wire              s_axi_bready_i,
  input  wire [ADDR_W-1:0] s_axi_araddr_i,
  input  wire              s_axi_arvalid_i,
  output reg               s_axi_arready_o,
  output reg  [31:0]       s_axi_rdata_o,
  output reg  [1:0]        s_axi_rresp_o,
  output reg               s_axi_rvalid_o,
  input  wire              s_axi_rready_i,
  input  wire              op_start_i,
  input  wire [3:0]        op_code_i,
  input  wire [31:0]       shift_count_i,
  output reg               op_done_o,
  output reg               busy_o,
  output reg  [31:0]       acc_o,
  output reg               zero_result_flag_o,
  output reg               negative_result_flag_o,
  output reg               valid_float_flag_o,
  output reg               sign_error_flag_o,
  output reg               non_real_operand_flag_o,
  output reg               operand_range_flag_o
);

localparam S_IDLE = 6'b000001;
localparam S_RED  = 6'b000010;
localparam S_CORD = 6'b000100;
localparam S_SQRT = 6'b001000;
localparam S_DIV  = 6'b010000;
localparam S_FIN  = 6'b100000;

reg        [5:0]        state;
reg        [3:0]        op;
reg signed [31:0]       x;
reg signed [31:0]       y;
reg signed [31:0]       z;
reg        [5:0]        it;
reg                     negc;
reg                     tsign;
reg                     ovf;
reg                     fl_nr;
reg                     fl_rng;
reg        [31:0]       res;
reg        [49:0]       rad;
reg        [28:0]       rem_s;
reg        [24:0]       root;
reg signed [9:0]        sq_sh;
reg        [55:0]       dn;
reg        [32:0]       drem;
reg        [31:0]       den;
reg        [55:0]       quo;
reg                     aw_hold;
reg        [ADDR_W-1:0] aw_addr;
reg                     w_hold;
reg        [31:0]       w_data;
reg        [3:0]        w_strb;
reg        [31:0]       shift_reg;

function [31:0] f2x;
  input [31:0] f;
  reg   [31:0] m;
  integer      e;
  begin
    m = {8'h00, 1'b1, f[22:0]};
    e = f[30:23] - 127;
    if (f[30:23] == 8'h00 || e < -25)
      f2x = 32'h0;
    else if (e >= -1)
      f2x = m << (e + 1);
    else
      f2x = m >> (-e - 1);
    if (f[31])
      f2x = -f2x;
  end
endfunction

function [31:0] x2f;
  input        s;
  input [55:0] mag;
  input integer sh;
  reg   [55:0] mn;
  integer      p;
  integer      i;
  integer      ex;
  begin
    p = 0;
    for (i = 0; i < 56; i = i + 1) begin
      if (mag[i])
        p = i;
    end
    ex = p + sh + 127;
    if (p >= 23)
      mn = mag >> (p - 23);
    else
      mn = mag << (23 - p);
    if (mag == 56'h0 || ex <= 0)
      x2f = 32'h0;
    else if (ex >= 255)
      x2f = {s, 8'hff, 23'h0};
    else
      x2f = {s, ex[7:0], mn[22:0]};
  end
endfunction

function [31:0] fxf;
  input [31:0] v;
  reg   [31:0] a;
  begin
    a = v[31] ? -v : v;
    fxf = x2f(v[31], {24'h0, a}, -24);
  end
endfunction

function [31:0] popcnt;
  input [31:0] v;
  integer      i;
  begin
    popcnt = 32'h0;
    for (i = 0; i < 32; i = i + 1)
      popcnt = popcnt + {31'h0, v[i]};
  end
endfunction

function [31:0] atan_t;
  input [5:0] i;
  begin
    case (i)
      6'd0: atan_t = `ARBU_AT0;
      6'd1: atan_t = `ARBU_AT1;
      6'd2: atan_t = `ARBU_AT2;
      6'd3: atan_t = `ARBU_AT3;
      6'd4: atan_t = `ARBU_AT4;
      6'd5: atan_t = `ARBU_AT5;
      6'd6: atan_t = `ARBU_AT6;
      6'd7: atan_t = `ARBU_AT7;
      6'd8: atan_t = `ARBU_AT8;
      default: atan_t = `ARBU_ONE >> i;
    endcase
  end
endfunction

function [31:0] bmerge;
  input [31:0] old;
  input [31:0] nw;
  input [3:0]  strb;
  integer      i;
  begin
    bmerge = old;
    for (i = 0; i < 4; i = i + 1) begin
      if (strb[i])
        bmerge[i*8 +: 8] = nw[i*8 +: 8];
    end
  end
endfunction

// Operand decode of the accumulator
wire        [7:0]  a_ex   = acc_o[30:23];
wire               a_nr   = a_ex == 8'hff;
wire               a_zero = a_ex == 8'h00;
wire        [23:0] a_m    = a_zero ? 24'h0 : {1'b1, acc_o[22:0]};
wire signed [9:0]  a_e    = $signed({2'b00, a_ex}) - 10'sd127;
wire        [31:0] a_fx   = f2x(acc_o);
wire        [31:0] a_abs  = a_fx[31] ? -a_fx : a_fx;
wire        [63:0] a_sq   = a_abs * a_abs;
wire               a_gt1  = a_ex > `ARBU_EXP_ONE || (a_ex == `ARBU_EXP_ONE && acc_o[22:0] != 23'h0);
wire signed [9:0]  a_p    = a_e - 10'sd23;
wire signed [9:0]  a_sh   = ((a_p - $signed({9'h0, a_p[0]})) >>> 1) - 10'sd12;
wire        [49:0] a_rad  = a_p[0] ? {1'b0, a_m, 25'h0} : {2'b00, a_m, 24'h0};
wire        [31:0] at_y   = a_e >= 0 ? {7'h0, a_m, 1'b0} : ({7'h0, a_m, 1'b0} >> (-a_e));
wire        [31:0] at_x   = a_e >= 0 ? (`ARBU_ONE >> a_e) : `ARBU_ONE;

// Command source: the sequencer strobe wins over a bus command
wire        wr_fire = aw_hold & w_hold & ~s_axi_bvalid_o;
wire        idle    = state == S_IDLE;
wire        go_axi  = wr_fire && aw_addr == `ARBU_A_CMD && w_strb[0] && !op_start_i;
wire        go      = idle && (op_start_i || go_axi);
wire [3:0]  go_op   = op_start_i ? op_code_i : w_data[3:0];
wire [31:0] go_cnt  = op_start_i ? shift_count_i : shift_reg;
wire [31:0] shl_res = go_cnt > 32'd31 ? 32'h0 : acc_o << go_cnt[4:0];
wire        shl_bad = go_cnt == 32'h0 || go_cnt > 32'd32;
wire        f_op    = go_op <= `ARBU_OP_SQRT;

// One CORDIC step
wire               vect = op == `ARBU_OP_ATAN || op == `ARBU_OP_ASIN || op == `ARBU_OP_ACOS;
wire signed [31:0] xs   = x >>> it;
wire signed [31:0] ys   = y >>> it;
wire        [31:0] at   = atan_t(it);
wire               dneg = vect ? ~y[31] : z[31];
wire        [32:0] cx   = dneg ? {x[31], x} + {ys[31], ys} : {x[31], x} - {ys[31], ys};
wire        [32:0] cy   = dneg ? {y[31], y} - {xs[31], xs} : {y[31], y} + {xs[31], xs};
wire        [32:0] cz   = dneg ? {z[31], z} + {1'b0, at} : {z[31], z} - {1'b0, at};
wire               c_ov = (cx[32] ^ cx[31]) | (cy[32] ^ cy[31]) | (cz[32] ^ cz[31]);

// Quadrant fold after range reduction
wire               z_hi   = z > $signed(`ARBU_HALF_PI);
wire               z_lo   = z < -$signed(`ARBU_HALF_PI);
wire signed [31:0] z_fold = z_hi ? $signed(`ARBU_PI) - z :
                            z_lo ? -$signed(`ARBU_PI) - z : z;

// Digit-by-digit square root step
wire [28:0] sq_rn = {rem_s[26:0], rad[49:48]};
wire [28:0] sq_tr = {2'b00, root, 2'b01};
wire        sq_ge = sq_rn >= sq_tr;

// Restoring divide step
wire [33:0] dv_t  = {drem, dn[55]};
wire        dv_ge = dv_t >= {2'b00, den};
wire [33:0] dv_s  = dv_t - {2'b00, den};

always @(posedge clk_sys_i) begin
  if (reset_i) begin
    state <= S_IDLE;
    op <= 4'h0;
    x <= 32'h0;
    y <= 32'h0;
    z <= 32'h0;
    it <= 6'h0;
    negc <= 1'b0;
    tsign <= 1'b0;
    ovf <= 1'b0;
    fl_nr <= 1'b0;
    fl_rng <= 1'b0;
    res <= 32'h0;
    rad <= 50'h0;
    rem_s <= 29'h0;
    root <= 25'h0;
    sq_sh <= 10'sd0;
    dn <= 56'h0;
    drem <= 33'h0;
    den <= 32'h0;
    quo <= 56'h0;
    op_done_o <= 1'b0;
    busy_o <= 1'b0;
    acc_o <= `ARBU_RST_ACC;
    zero_result_flag_o <= 1'b0;
    negative_result_flag_o <= 1'b0;
    valid_float_flag_o <= 1'b0;
    sign_error_flag_o <= 1'b0;
    non_real_operand_flag_o <= 1'b0;
    operand_range_flag_o <= 1'b0;
  end else begin
    op_done_o <= 1'b0;
    case (state)
      S_IDLE: begin
        if (wr_fire && aw_addr == `ARBU_A_ACC)
          acc_o <= bmerge(acc_o, w_data, w_strb);
        if (go) begin
          busy_o <= 1'b1;
          op <= go_op;
          ovf <= 1'b0;
          fl_nr <= 1'b0;
          fl_rng <= 1'b0;
          it <= 6'h0;
          negc <= 1'b0;
          rem_s <= 29'h0;
          root <= 25'h0;
          state <= S_FIN;
          if (f_op && a_nr) begin
            res <= `ARBU_NAN;
            fl_nr <= 1'b1;
          end else begin
            case (go_op)
              `ARBU_OP_SIN, `ARBU_OP_COS, `ARBU_OP_TAN: begin
                if (a_ex >= `ARBU_EXP_BIG) begin
                  res <= `ARBU_NAN;
                  fl_rng <= 1'b1;
                end else begin
                  z <= a_fx;
                  state <= S_RED;
                end
              end
              `ARBU_OP_ATAN: begin
                x <= at_x;
                y <= acc_o[31] ? -at_y : at_y;
                z <= 32'h0;
                state <= S_CORD;
              end
              `ARBU_OP_ASIN, `ARBU_OP_ACOS: begin
                if (a_gt1) begin
                  res <= `ARBU_NAN;
                end else begin
                  rad <= {2'b01, 48'h0} - a_sq[49:0];
                  y <= a_fx;
                  state <= S_SQRT;
                end
              end
              `ARBU_OP_SQRT: begin
                if (a_zero) begin
                  res <= 32'h0;
                end else if (acc_o[31]) begin
                  res <= `ARBU_NAN;
                end else begin
                  rad <= a_rad;
                  sq_sh <= a_sh;
                  state <= S_SQRT;
                end
              end
              `ARBU_OP_POP:
                res <= popcnt(acc_o);
              `ARBU_OP_SHL: begin
                res <= shl_res;
                fl_rng <= shl_bad;
              end
              default:
                res <= acc_o;
            endcase
          end
        end
      end
      S_RED: begin
        if (z > $signed(`ARBU_PI)) begin
          z <= z - $signed(`ARBU_TWO_PI);
        end else if (z < -$signed(`ARBU_PI)) begin
          z <= z + $signed(`ARBU_TWO_PI);
        end else begin
          z <= z_fold;
          negc <= z_hi | z_lo;
          x <= `ARBU_K;
          y <= 32'h0;
          state <= S_CORD;
        end
      end
      S_CORD: begin
        x <= cx[31:0];
        y <= cy[31:0];
        z <= cz[31:0];
        ovf <= ovf | c_ov;
        it <= it + 6'd1;
        if (it == `ARBU_CORD_N - 6'd1) begin
          it <= 6'h0;
          state <= S_FIN;
          case (op)
            `ARBU_OP_SIN: res <= fxf(cy[31:0]);
            `ARBU_OP_COS: res <= fxf(negc ? -cx[31:0] : cx[31:0]);
            `ARBU_OP_ACOS: res <= fxf(`ARBU_HALF_PI - cz[31:0]);
            `ARBU_OP_TAN: begin
              state <= S_DIV;
              tsign <= cy[31] ^ cx[31] ^ negc;
              dn <= {(cy[31] ? -cy[31:0] : cy[31:0]), 24'h0};
              den <= cx[31] ? -cx[31:0] : cx[31:0];
              drem <= 33'h0;
              quo <= 56'h0;
            end
            default: res <= fxf(cz[31:0]);
          endcase
        end
      end
      S_SQRT: begin
        rad <= {rad[47:0], 2'b00};
        rem_s <= sq_ge ? sq_rn - sq_tr : sq_rn;
        root <= {root[23:0], sq_ge};
        it <= it + 6'd1;
        if (it == `ARBU_SQRT_N - 6'd1) begin
          it <= 6'h0;
          if (op == `ARBU_OP_SQRT) begin
            res <= x2f(1'b0, {31'h0, root[23:0], sq_ge}, sq_sh);
            state <= S_FIN;
          end else begin
            x <= {7'h0, root[23:0], sq_ge};
            z <= 32'h0;
            state <= S_CORD;
          end
        end
      end
      S_DIV: begin
        dn <= {dn[54:0], 1'b0};
        drem <= dv_ge ? dv_s[32:0] : dv_t[32:0];
        quo <= {quo[54:0], dv_ge};
        it <= it + 6'd1;
        if (it == `ARBU_DIV_N - 6'd1) begin
          state <= S_FIN;
          if (den == 32'h0) begin
            res <= `ARBU_NAN;
            fl_rng <= 1'b1;
          end else begin
            res <= x2f(tsign, {quo[54:0], dv_ge}, -24);
          end
        end
      end
      S_FIN: begin
        acc_o <= res;
        op_done_o <= 1'b1;
        busy_o <= 1'b0;
        state <= S_IDLE;
        if (op <= `ARBU_OP_SQRT) begin
          zero_result_flag_o <= res[30:0] == 31'h0;
          negative_result_flag_o <= res[31] & (res[30:0] != 31'h0);
          valid_float_flag_o <= res[30:23] != 8'hff;
          sign_error_flag_o <= ovf;
          non_real_operand_flag_o <= fl_nr;
          operand_range_flag_o <= fl_rng;
        end else if (op == `ARBU_OP_POP || op == `ARBU_OP_SHL) begin
          zero_result_flag_o <= res == 32'h0;
          negative_result_flag_o <= res[31];
          if (op == `ARBU_OP_SHL)
            operand_range_flag_o <= fl_rng;
        end
      end
      default:
        state <= S_IDLE;
    endcase
  end
end

// AXI4-Lite slave, one write and one read under way at a time
always @(posedge clk_sys_i) begin
  if (reset_i) begin
    s_axi_awready_o <= 1'b1;
    s_axi_wready_o <= 1'b1;
    s_axi_bvalid_o <= 1'b0;
    s_axi_bresp_o <= `ARBU_RESP_OK;
    s_axi_arready_o <= 1'b1;
    s_axi_rvalid_o <= 1'b0;
    s_axi_rresp_o <= `ARBU_RESP_OK;
    s_axi_rdata_o <= 32'h0;
    aw_hold <= 1'b0;
    aw_addr <= {ADDR_W{1'b0}};
    w_hold <= 1'b0;
    w_data <= 32'h0;
    w_strb <= 4'h0;
    shift_reg <= `ARBU_RST_SHIFT;
  end else begin
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_hold <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
      s_axi_awready_o <= 1'b0;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_hold <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
      s_axi_wready_o <= 1'b0;
    end
    if (wr_fire) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      s_axi_bvalid_o <= 1'b1;
      if (aw_addr == `ARBU_A_SHIFT)
        shift_reg <= bmerge(shift_reg, w_data, w_strb);
      if (aw_addr == `ARBU_A_ACC || aw_addr == `ARBU_A_CMD ||
          aw_addr == `ARBU_A_SHIFT || aw_addr == `ARBU_A_STAT)
        s_axi_bresp_o <= `ARBU_RESP_OK;
      else
        s_axi_bresp_o <= `ARBU_RESP_DEC;
    end
    if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= `ARBU_RESP_OK;
      case (s_axi_araddr_i)
        `ARBU_A_ACC:   s_axi_rdata_o <= acc_o;
        `ARBU_A_CMD:   s_axi_rdata_o <= {28'h0, op};
        `ARBU_A_SHIFT: s_axi_rdata_o <= shift_reg;
        `ARBU_A_STAT:  s_axi_rdata_o <= {23'h0, busy_o, 2'b00, operand_range_flag_o,
                                         non_real_operand_flag_o, sign_error_flag_o,
                                         valid_float_flag_o, negative_result_flag_o,
                                         zero_result_flag_o};
        default: begin
          s_axi_rdata_o <= 32'h0;
          s_axi_rresp_o <= `ARBU_RESP_DEC;
        end
      endcase
    end
    if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end
end

endmodule

/* dv/arbu_acc_math_properties.sv */
`timescale 1ns/1ps
`include "arbu_consts.vh"
module arbu_acc_math_chk (
  input wire        clk_sys_i,
  input wire        reset_i,
  input wire        s_axi_awvalid_i,
  input wire        s_axi_awready_o,
  input wire        s_axi_wvalid_i,
  input wire        s_axi_wready_o,
  input wire        s_axi_bvalid_o,
  input wire        op_start_i,
  input wire [3:0]  op_code_i,
  input wire [31:0] shift_count_i,
  input wire        op_done_o,
  input wire        busy_o,
  input wire [31:0] acc_o,
  input wire        zero_result_flag_o,
  input wire        negative_result_flag_o,
  input wire        valid_float_flag_o,
  input wire        sign_error_flag_o,
  input wire        non_real_operand_flag_o,
  input wire        operand_range_flag_o
);
  reg  [3:0] last_op;
  wire       take = op_start_i && !busy_o;
  wire       fdone = op_done_o && (last_op <= `ARBU_OP_SQRT);
  wire [5:0] flg = {operand_range_flag_o, non_real_operand_flag_o, sign_error_flag_o,
                    valid_float_flag_o, negative_result_flag_o, zero_result_flag_o};
  // Remembers which sequencer-started operation the next done belongs to
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      last_op <= 4'hf;
    end else begin
      last_op <= take ? op_code_i : op_done_o ? 4'hf : last_op;
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  a_done_pulse: assert property (op_done_o |=> !op_done_o)
    else $error("done strobe longer than one cycle");
  a_start_busy: assert property (take |=> busy_o)
    else $error("accepted start did not raise busy");
  a_busy_end: assert property ($fell(busy_o) && !$past(reset_i) |-> op_done_o)
    else $error("busy fell without done");
  a_pop_result: assert property (take && op_code_i == `ARBU_OP_POP
    |-> ##2 op_done_o && acc_o == $countones($past(acc_o, 2)))
    else $error("population count wrong or late");
  a_shift_result: assert property (take && op_code_i == `ARBU_OP_SHL
    && shift_count_i inside {[1:32]}
    |-> ##2 op_done_o && acc_o == ($past(acc_o, 2) << $past(shift_count_i, 2)))
    else $error("left shift wrong or late");
  a_zero_flag: assert property (op_done_o |-> zero_result_flag_o == (acc_o == 32'h0))
    else $error("zero flag disagrees with result");
  a_neg_flag: assert property (op_done_o |-> negative_result_flag_o == acc_o[31])
    else $error("negative flag disagrees with result");
  a_valid_float: assert property (fdone
    |-> valid_float_flag_o == (acc_o[30:23] != 8'hff))
    else $error("valid float flag disagrees with result");
  a_nonreal_nan: assert property (fdone && non_real_operand_flag_o |-> acc_o == `ARBU_NAN)
    else $error("non-real operand did not give quiet nan");
  a_flags_steady: assert property (!op_done_o && !$past(reset_i) |-> $stable(flg))
    else $error("flags changed outside done");
  a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
    else $error("write response not two cycles after handshake");
  c_float_done: cover property (fdone);
  c_pop_start: cover property (take && op_code_i == `ARBU_OP_POP);
  c_write_resp: cover property (s_axi_bvalid_o);
endmodule
bind arbu_acc_math arbu_acc_math_chk chk_i (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .op_start_i(op_start_i), .op_code_i(op_code_i), .shift_count_i(shift_count_i),
  .op_done_o(op_done_o), .busy_o(busy_o), .acc_o(acc_o),
  .zero_result_flag_o(zero_result_flag_o), .negative_result_flag_o(negative_result_flag_o),
  .valid_float_flag_o(valid_float_flag_o), .sign_error_flag_o(sign_error_flag_o),
  .non_real_operand_flag_o(non_real_operand_flag_o),
  .operand_range_flag_o(operand_range_flag_o));

/* dv/arbu_seq_model.sv */
`timescale 1ns/1ps
module arbu_seq_model (
  input  wire        clk_sys_i,
  input  wire        done_i,
  input  wire [31:0] acc_i,
  input  wire [5:0]  flags_i,
  output reg         start_o = 1'b0,
  output reg  [3:0]  code_o = 4'h0,
  output reg  [31:0] count_o = 32'h0
);
  reg [31:0] res_acc = 32'h0;
  reg [5:0]  res_flg = 6'h0;
  // Issues one operation and holds the next until done
  task automatic issue(input [3:0] c, input [31:0] n);
    integer k;
    begin
      @(posedge clk_sys_i);
      start_o <= 1'b1;
      code_o <= c;
      count_o <= n;
      @(posedge clk_sys_i);
      start_o <= 1'b0;
      code_o <= ~c;
      count_o <= ~n;
      k = 0;
      while (!done_i && k < 400) begin
        @(posedge clk_sys_i);
        k = k + 1;
      end
      res_acc = acc_i;
      res_flg = flags_i;
    end
  endtask
endmodule

/* dv/test_arbu_acc_math.sv */
`timescale 1ns/1ps
`include "arbu_consts.vh"
module test_arbu_acc_math;
  reg         clk_sys_i = 1'b0;
  reg         reset_i = 1'b1;
  reg  [4:0]  aw_addr = 5'h0;
  reg         aw_valid = 1'b0;
  reg  [31:0] w_data = 32'h0;
  reg  [3:0]  w_strb = 4'hf;
  reg         w_valid = 1'b0;
  reg         b_ready = 1'b0;
  reg  [4:0]  ar_addr = 5'h0;
  reg         ar_valid = 1'b0;
  reg         r_ready = 1'b0;
  reg  [1:0]  resp = 2'h0;
  reg  [31:0] rdat = 32'h0;
  integer     error_cnt = 0;
  integer     samples_checked = 0;
  wire        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, start, done, busy;
  wire [1:0]  b_resp, r_resp;
  wire [31:0] r_data, acc, cnt;
  wire [3:0]  code;
  wire [5:0]  flg;
  arbu_acc_math arbu_acc_math_i (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .s_axi_awaddr_i(aw_addr),
    .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_rdy), .s_axi_wdata_i(w_data),
    .s_axi_wstrb_i(w_strb), .s_axi_wvalid_i(w_valid), .s_axi_wready_o(w_rdy),
    .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_vld), .s_axi_bready_i(b_ready),
    .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid), .s_axi_arready_o(ar_rdy),
    .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_vld),
    .s_axi_rready_i(r_ready), .op_start_i(start), .op_code_i(code), .shift_count_i(cnt),
    .op_done_o(done), .busy_o(busy), .acc_o(acc), .zero_result_flag_o(flg[0]),
    .negative_result_flag_o(flg[1]), .valid_float_flag_o(flg[2]),
    .sign_error_flag_o(flg[3]), .non_real_operand_flag_o(flg[4]),
    .operand_range_flag_o(flg[5]));
  arbu_seq_model arbu_seq_model_i (
    .clk_sys_i(clk_sys_i), .done_i(done), .acc_i(acc), .flags_i(flg),
    .start_o(start), .code_o(code), .count_o(cnt));
  always #20 clk_sys_i = ~clk_sys_i;
  task automatic axw(input [4:0] a, input [31:0] d);
    integer k;
    begin
      aw_addr <= a;
      w_data <= d;
      aw_valid <= 1'b1;
      w_valid <= 1'b1;
      b_ready <= 1'b1;
      k = 0;
      do begin
        @(posedge clk_sys_i);
        if (aw_rdy) aw_valid <= 1'b0;
        if (w_rdy) w_valid <= 1'b0;
        k = k + 1;
      end while (!b_vld && k < 100);
      resp = b_resp;
    end
  endtask
  task automatic axr(input [4:0] a);
    integer k;
    begin
      ar_addr <= a;
      ar_valid <= 1'b1;
      r_ready <= 1'b1;
      k = 0;
      do begin
        @(posedge clk_sys_i);
        if (ar_rdy) ar_valid <= 1'b0;
        k = k + 1;
      end while (!r_vld && k < 100);
      resp = r_resp;
      rdat = r_data;
    end
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Float results may differ from exact by up to 63 units in the last place
  task automatic chk_near(input [31:0] got, input [31:0] exp);
    reg [31:0] d;
    begin
      d = (got > exp) ? got - exp : exp - got;
      if (!$isunknown(got) && d < 32'h40) chk(exp, exp);
      else chk(got, exp);
    end
  endtask
  task automatic int_case(input [31:0] a, input [3:0] c, input [31:0] n,
                          input [31:0] e, input [2:0] ef);
    begin
      axw(`ARBU_A_ACC, a);
      arbu_seq_model_i.issue(c, n);
      chk(arbu_seq_model_i.res_acc, e);
      chk({29'h0, arbu_seq_model_i.res_flg[5], arbu_seq_model_i.res_flg[1:0]}, {29'h0, ef});
    end
  endtask
  task automatic flt_case(input [3:0] c, input [31:0] a, input [31:0] e, input [3:0] ef);
    begin
      axw(`ARBU_A_ACC, a);
      arbu_seq_model_i.issue(c, 32'h0);
      chk_near(arbu_seq_model_i.res_acc, e);
      chk({28'h0, arbu_seq_model_i.res_flg[4], arbu_seq_model_i.res_flg[2:0]}, {28'h0, ef});
    end
  endtask
  task tally_and_finish;
    begin
      $display("TB: errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask
  initial begin
    #(40 * 20000);
    error_cnt = error_cnt + 1;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    axr(`ARBU_A_ACC);
    chk(rdat, `ARBU_RST_ACC);
    axr(`ARBU_A_SHIFT);
    chk(rdat, `ARBU_RST_SHIFT);
    axw(`ARBU_A_STAT, 32'hffff_ffff);
    axr(`ARBU_A_STAT);
    chk(rdat, 32'h0);
    axw(5'h10, 32'h1);
    chk({30'h0, resp}, {30'h0, `ARBU_RESP_DEC});
    axr(5'h14);
    chk({30'h0, resp}, {30'h0, `ARBU_RESP_DEC});
    chk(rdat, 32'h0);
    axw(`ARBU_A_ACC, 32'hffff_ffff);
    w_strb <= 4'h1;
    axw(`ARBU_A_ACC, 32'h0000_00aa);
    w_strb <= 4'hf;
    axr(`ARBU_A_ACC);
    chk(rdat, 32'hffff_ffaa);
    int_case(32'hf0f0_0001, `ARBU_OP_POP, 32'h0, 32'h9, 3'b000);
    int_case(32'h0000_0000, `ARBU_OP_POP, 32'h0, 32'h0, 3'b001);
    int_case(32'hffff_ffff, `ARBU_OP_POP, 32'h0, 32'h20, 3'b000);
    int_case(32'h8000_0001, `ARBU_OP_SHL, 32'h1, 32'h2, 3'b000);
    int_case(32'h1234_5678, `ARBU_OP_SHL, 32'h4, 32'h2345_6780, 3'b000);
    int_case(32'hffff_ffff, `ARBU_OP_SHL, 32'h20, 32'h0, 3'b001);
    int_case(32'h0000_0001, `ARBU_OP_SHL, 32'h21, 32'h0, 3'b101);
    int_case(32'h4000_0001, `ARBU_OP_SHL, 32'h1, 32'h8000_0002, 3'b010);
    // Trig operands are already in radians
    flt_case(`ARBU_OP_SIN, 32'h3fc9_0fdb, 32'h3f80_0000, 4'b0100);
    flt_case(`ARBU_OP_SIN, 32'hbfc9_0fdb, 32'hbf80_0000, 4'b0110);
    flt_case(`ARBU_OP_COS, 32'h0000_0000, 32'h3f80_0000, 4'b0100);
    flt_case(`ARBU_OP_TAN, 32'h3f49_0fdb, 32'h3f80_0000, 4'b0100);
    flt_case(`ARBU_OP_ASIN, 32'h3f80_0000, 32'h3fc9_0fdb, 4'b0100);
    flt_case(`ARBU_OP_ACOS, 32'hbf80_0000, 32'h4049_0fdb, 4'b0100);
    flt_case(`ARBU_OP_ATAN, 32'h3f80_0000, 32'h3f49_0fdb, 4'b0100);
    flt_case(`ARBU_OP_SQRT, 32'h4080_0000, 32'h4000_0000, 4'b0100);
    flt_case(`ARBU_OP_SQRT, 32'h0000_0000, 32'h0000_0000, 4'b0101);
    flt_case(`ARBU_OP_SQRT, 32'hc080_0000, `ARBU_NAN, 4'b0000);
    flt_case(`ARBU_OP_ASIN, 32'h4000_0000, `ARBU_NAN, 4'b0000);
    flt_case(`ARBU_OP_SIN, `ARBU_NAN, `ARBU_NAN, 4'b1000);
    axw(`ARBU_A_ACC, 32'h42c8_0000);
    arbu_seq_model_i.issue(`ARBU_OP_SIN, 32'h0);
    chk({31'h0, arbu_seq_model_i.res_flg[5]}, 32'h1);
    axr(`ARBU_A_STAT);
    chk(rdat, 32'h0000_0020);
    axw(`ARBU_A_SHIFT, 32'h4);
    axw(`ARBU_A_CMD, {28'h0, `ARBU_OP_SHL});
    axr(`ARBU_A_ACC);
    chk(rdat, 32'hfc00_0000);
    tally_and_finish;
  end
endmodule
